// *** design/vpgc_pkg.sv ***
package vpgc_pkg;

  localparam logic [7:0]  ADDR_TERM_GAIN   = 8'h34;
  localparam logic [7:0]  ADDR_POWER_MODE  = 8'h35;
  localparam logic [7:0]  ADDR_BUF_FB      = 8'h36;
  localparam logic [7:0]  ADDR_CHAN_GAIN   = 8'h39;
  localparam logic [7:0]  ADDR_ATTEN_FILT  = 8'h3b;

  localparam logic [15:0] RST_TERM_GAIN    = 16'h0000;
  localparam logic [15:0] RST_POWER_MODE   = 16'h0000;
  localparam logic [15:0] RST_BUF_FB       = 16'h0000;
  localparam logic [15:0] RST_CHAN_GAIN    = 16'h0000;
  localparam logic [15:0] RST_ATTEN_FILT   = 16'h0000;

  // writable masks: reserved bits read as zero
  localparam logic [15:0] MASK_TERM_GAIN   = 16'hf7ff;
  localparam logic [15:0] MASK_POWER_MODE  = 16'hfcff;
  localparam logic [15:0] MASK_BUF_FB      = 16'h001f;
  localparam logic [15:0] MASK_CHAN_GAIN   = 16'hffff;
  localparam logic [15:0] MASK_ATTEN_FILT  = 16'h03fc;

  localparam int TERM_IND_LSB   = 0;
  localparam int TERM_IND_EN    = 5;
  localparam int TERM_PRESET_LSB = 6;
  localparam int TERM_ENABLE    = 8;
  localparam int COMMON_GAIN_LSB = 13;
  localparam int PER_CH_GAIN_EN = 15;
  localparam int PWR_LOW        = 10;
  localparam int PWR_MED        = 11;
  localparam int PWR_ATT_PGA    = 12;
  localparam int PWR_INAMP      = 13;
  localparam int PWR_PARTIAL    = 14;
  localparam int PWR_FULL       = 15;
  localparam int AF_HPF_LSB     = 2;
  localparam int AF_ATT_LSB     = 4;
  localparam int AF_ATT_EN      = 7;
  localparam int AF_BUF_ON      = 8;
  localparam int AF_TEST_ROUTE  = 9;

  localparam logic [1:0] GAIN_18DB = 2'h0;
  localparam logic [1:0] GAIN_24DB = 2'h1;
  localparam logic [1:0] GAIN_12DB = 2'h2;

  localparam logic [1:0] PRESET_50   = 2'h0;
  localparam logic [1:0] PRESET_100  = 2'h1;
  localparam logic [1:0] PRESET_200  = 2'h2;
  localparam logic [1:0] PRESET_400  = 2'h3;

  typedef enum logic [2:0] {
    VPGC_PWR_NORMAL = 3'b001,
    VPGC_PWR_MEDIUM = 3'b010,
    VPGC_PWR_LOW    = 3'b100
  } vpgc_pwr_mode_t;

  typedef struct packed {
    logic       attenuator_gain_stage_off;
    logic       input_amp_off;
    logic       chain_partial_off;
    logic       chain_full_off;
  } vpgc_power_t;

  typedef struct packed {
    logic [1:0] input_highpass_corner;
    logic       digital_atten_enable;
    logic [2:0] digital_atten_steps;
    logic       buffer_power_on;
    logic       gain_stage_test_route;
    logic [4:0] buffer_feedback_code;
  } vpgc_atten_t;

endpackage

// *** design/vpgc_regs.sv ***
`timescale 1ns/10ps
// Summary of operation
// - bit 11 selects medium power, low clear
// - bit 12 powers down attenuator and gain
// - bit 13 powers down input amplifier only
// - bit 14 partial chain power-down, fast wake
// - bit 15 full power-down, overrides bit 14
// - buffer feedback resistors selected bit by bit
// - buffer feedback effective only in test route
// - eight two-bit per-channel gain fields
// - bits 3:2 select high-pass corner
// - bits 6:4 digital attenuation in 6 dB steps
// - bit 7 selects digital attenuator control
// - bit 8 high turns buffer on
// - bit 9 routes gain outputs to test
// - individual termination code enables resistors
// - zero termination code means high impedance
// - preset termination decoded by input gain
// - bit 15 of 52 enables per-channel gain
// - individual termination needs enable bit 5
// - bit 10 selects low power, medium clear
module vpgc_regs
  import vpgc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output vpgc_pwr_mode_t   power_mode,
  output vpgc_power_t      power_ctl,
  output vpgc_atten_t      atten_ctl,
  output logic [4:0]       buffer_fb_active,
  output logic [15:0]      channel_gain,
  output logic [4:0]       termination_active,
  output logic             termination_enable
);

  logic [15:0] term_gain_reg;
  logic [15:0] power_mode_reg;
  logic [15:0] buf_fb_reg;
  logic [15:0] chan_gain_reg;
  logic [15:0] atten_filt_reg;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] rdata_reg;
  logic        req;
  logic        hit;
  logic [4:0]  adr_sel;
  logic        term_gain_we;
  logic        power_mode_we;
  logic        buf_fb_we;
  logic        chan_gain_we;
  logic        atten_filt_we;
  logic [15:0] rd_mux;

  // preset feedback code; 50 ohm unavailable at 12 dB gives high impedance
  function automatic logic [4:0] preset_code(input logic [1:0] preset,
                                             input logic [1:0] gain);
    logic [4:0] code;
    code = 5'h00;
    unique case (gain)
      GAIN_24DB: begin
        unique case (preset)
          PRESET_50:  code = 5'h01;
          PRESET_100: code = 5'h02;
          PRESET_200: code = 5'h04;
          PRESET_400: code = 5'h08;
        endcase
      end
      GAIN_12DB: begin
        unique case (preset)
          PRESET_50:  code = 5'h00;
          PRESET_100: code = 5'h03;
          PRESET_200: code = 5'h06;
          PRESET_400: code = 5'h0c;
        endcase
      end
      // reserved gain code falls back to the 18 dB set
      default: begin
        unique case (preset)
          PRESET_50:  code = 5'h07;
          PRESET_100: code = 5'h0e;
          PRESET_200: code = 5'h1c;
          PRESET_400: code = 5'h18;
        endcase
      end
    endcase
    return code;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel,
                                        input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & mask;
  endfunction

  // one-hot register select; all zero for an unmapped index
  function automatic logic [4:0] reg_decode(input logic [7:0] adr);
    logic [4:0] onehot;
    onehot = 5'h00;
    unique case (adr)
      ADDR_TERM_GAIN:  onehot = 5'h01;
      ADDR_POWER_MODE: onehot = 5'h02;
      ADDR_BUF_FB:     onehot = 5'h04;
      ADDR_CHAN_GAIN:  onehot = 5'h08;
      ADDR_ATTEN_FILT: onehot = 5'h10;
      default:         onehot = 5'h00;
    endcase
    return onehot;
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign adr_sel = reg_decode(wb_adr_i);
  assign hit = |adr_sel;

  // a write lands at the edge that takes the request
  assign term_gain_we  = req && wb_we_i && adr_sel[0];
  assign power_mode_we = req && wb_we_i && adr_sel[1];
  assign buf_fb_we     = req && wb_we_i && adr_sel[2];
  assign chan_gain_we  = req && wb_we_i && adr_sel[3];
  assign atten_filt_we = req && wb_we_i && adr_sel[4];

  always_comb begin
    rd_mux = 16'h0000;
    unique case (wb_adr_i)
      ADDR_TERM_GAIN:  rd_mux = term_gain_reg;
      ADDR_POWER_MODE: rd_mux = power_mode_reg;
      ADDR_BUF_FB:     rd_mux = buf_fb_reg;
      ADDR_CHAN_GAIN:  rd_mux = chan_gain_reg;
      ADDR_ATTEN_FILT: rd_mux = atten_filt_reg;
      default:         rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req && hit;
      err_reg <= req && !hit;
    end
  end

  // read data stands only for the acknowledged cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= (req && hit && !wb_we_i) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  // reserved bits forced to zero regardless of host writes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      term_gain_reg <= RST_TERM_GAIN;
    end else if (term_gain_we) begin
      term_gain_reg <= merge(term_gain_reg, wb_dat_i, wb_sel_i, MASK_TERM_GAIN);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_mode_reg <= RST_POWER_MODE;
    end else if (power_mode_we) begin
      power_mode_reg <= merge(power_mode_reg, wb_dat_i, wb_sel_i, MASK_POWER_MODE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      buf_fb_reg <= RST_BUF_FB;
    end else if (buf_fb_we) begin
      buf_fb_reg <= merge(buf_fb_reg, wb_dat_i, wb_sel_i, MASK_BUF_FB);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      chan_gain_reg <= RST_CHAN_GAIN;
    end else if (chan_gain_we) begin
      chan_gain_reg <= merge(chan_gain_reg, wb_dat_i, wb_sel_i, MASK_CHAN_GAIN);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      atten_filt_reg <= RST_ATTEN_FILT;
    end else if (atten_filt_we) begin
      atten_filt_reg <= merge(atten_filt_reg, wb_dat_i, wb_sel_i, MASK_ATTEN_FILT);
    end
  end

  // power mode; both low and medium set is undefined, kept at normal
  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_mode <= VPGC_PWR_NORMAL;
    end else begin
      unique case (power_mode_reg[PWR_MED:PWR_LOW])
        2'b10:   power_mode <= VPGC_PWR_MEDIUM;
        2'b01:   power_mode <= VPGC_PWR_LOW;
        default: power_mode <= VPGC_PWR_NORMAL;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_ctl <= '0;
    end else begin
      power_ctl.attenuator_gain_stage_off <= power_mode_reg[PWR_ATT_PGA];
      power_ctl.input_amp_off             <= power_mode_reg[PWR_INAMP];
      power_ctl.chain_full_off            <= power_mode_reg[PWR_FULL];
      power_ctl.chain_partial_off         <= power_mode_reg[PWR_PARTIAL] &&
                                             !power_mode_reg[PWR_FULL];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      atten_ctl <= '0;
    end else begin
      atten_ctl.input_highpass_corner <= atten_filt_reg[AF_HPF_LSB +: 2];
      atten_ctl.digital_atten_enable  <= atten_filt_reg[AF_ATT_EN];
      atten_ctl.digital_atten_steps   <= atten_filt_reg[AF_ATT_EN] ?
                                         atten_filt_reg[AF_ATT_LSB +: 3] : 3'h0;
      atten_ctl.buffer_power_on       <= atten_filt_reg[AF_BUF_ON];
      atten_ctl.gain_stage_test_route <= atten_filt_reg[AF_TEST_ROUTE];
      atten_ctl.buffer_feedback_code  <= buf_fb_reg[4:0];
    end
  end

  // feedback code reaches the buffer only while the test route is on
  always_ff @(posedge core_clk) begin
    if (srst) begin
      buffer_fb_active <= 5'h00;
    end else begin
      buffer_fb_active <= atten_filt_reg[AF_TEST_ROUTE] ? buf_fb_reg[4:0] : 5'h00;
    end
  end

  // per-channel gain or common gain replicated to all eight channels
  always_ff @(posedge core_clk) begin
    if (srst) begin
      channel_gain <= 16'h0000;
    end else if (term_gain_reg[PER_CH_GAIN_EN]) begin
      channel_gain <= chan_gain_reg;
    end else begin
      channel_gain <= {8{term_gain_reg[COMMON_GAIN_LSB +: 2]}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      termination_enable <= 1'b0;
    end else begin
      termination_enable <= term_gain_reg[TERM_ENABLE];
    end
  end

  // individual code only once its enable is set, else the preset decoder
  always_ff @(posedge core_clk) begin
    if (srst) begin
      termination_active <= 5'h00;
    end else begin
      if (term_gain_reg[TERM_IND_EN]) begin
        termination_active <= term_gain_reg[TERM_IND_LSB +: 5];
      end else begin
        termination_active <= preset_code(term_gain_reg[TERM_PRESET_LSB +: 2],
                                          term_gain_reg[COMMON_GAIN_LSB +: 2]);
      end
    end
  end

endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import vpgc_pkg::*;
;
  logic           core_clk = 1'b0;
  logic           srst = 1'b1;
  logic           cyc, stb, we, ack, err, ten, e;
  logic [7:0]     adr;
  logic [3:0]     sel;
  logic [31:0]    wdat, rdat;
  vpgc_pwr_mode_t pmode;
  vpgc_power_t    pctl;
  vpgc_atten_t    actl;
  logic [4:0]     fb, term;
  logic [15:0]    gain, q;
  int             err_count = 0;
  int             compares = 0;
  logic [7:0]     ad [5] = '{ADDR_TERM_GAIN, ADDR_POWER_MODE, ADDR_BUF_FB, ADDR_CHAN_GAIN,
                             ADDR_ATTEN_FILT};
  logic [15:0]    mk [5] = '{MASK_TERM_GAIN, MASK_POWER_MODE, MASK_BUF_FB, MASK_CHAN_GAIN,
                             MASK_ATTEN_FILT};
  logic [15:0]    wd [5] = '{16'hbfff, 16'hfcff, 16'h001f, 16'h6666, 16'hffff};
  logic [15:0]    pw_d [7] = '{16'h0800, 16'h0400, 16'h0c00, 16'h1000, 16'h2000, 16'h4000,
                               16'hc000};
  logic [6:0]     pw_e [7] = '{7'h20, 7'h40, 7'h10, 7'h18, 7'h14, 7'h12, 7'h11};
  always #50 core_clk = ~core_clk;
  vpgc_regs DUT (.core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .power_mode(pmode), .power_ctl(pctl), .atten_ctl(actl),
    .buffer_fb_active(fb), .channel_gain(gain), .termination_active(term),
    .termination_enable(ten));
  vpgc_host host (.core_clk(core_clk), .wb_ack_o(ack), .wb_err_o(err), .wb_dat_o(rdat),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat));
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] v);
    compares++;
    if (v !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
    host.xfer(1'b1, a, s, d, q, e);
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    host.xfer(1'b0, a, 4'h3, 16'h0000, q, e);
    chk("read", x, q);
  endtask
  task automatic summarize();
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    foreach (ad[i]) rd(ad[i], 16'h0000);
    chk("mode", 16'h0001, {13'h0, pmode});
    foreach (ad[i]) begin
      wr(ad[i], 4'h3, wd[i]);
      rd(ad[i], wd[i] & mk[i]);
    end
    host.xfer(1'b1, 8'h37, 4'h3, 16'hffff, q, e);
    chk("err", 16'h0001, {15'h0, e});
    foreach (pw_d[i]) begin
      wr(ADDR_POWER_MODE, 4'h3, pw_d[i]);
      chk("power", {9'h0, pw_e[i]}, {9'h0, pmode, pctl});
    end
    wr(ADDR_TERM_GAIN, 4'h3, 16'h0135);
    chk("term", 16'h0035, {10'h0, ten, term});
    wr(ADDR_TERM_GAIN, 4'h3, 16'h0120);
    chk("term", 16'h0020, {10'h0, ten, term});
    wr(ADDR_TERM_GAIN, 4'h3, 16'h2140);
    chk("term", 16'h0022, {10'h0, ten, term});
    wr(ADDR_TERM_GAIN, 4'h3, 16'h0115);
    chk("term", 16'h0027, {10'h0, ten, term});
    wr(ADDR_TERM_GAIN, 4'h3, 16'h8000);
    wr(ADDR_CHAN_GAIN, 4'h3, 16'h9624);
    chk("gain", 16'h9624, gain);
    wr(ADDR_CHAN_GAIN, 4'h1, 16'h5a5a);
    chk("gain", 16'h965a, gain);
    wr(ADDR_TERM_GAIN, 4'h3, 16'h4100);
    chk("term", 16'h0020, {10'h0, ten, term});
    chk("gain", 16'haaaa, gain);
    wr(ADDR_TERM_GAIN, 4'h3, 16'h0140);
    chk("term", 16'h002e, {10'h0, ten, term});
    chk("gain", 16'h0000, gain);
    wr(ADDR_BUF_FB, 4'h3, 16'h0013);
    wr(ADDR_ATTEN_FILT, 4'h3, 16'h03d4);
    chk("atten", 16'h0ef3, {3'h0, actl});
    chk("fb", 16'h0013, {11'h0, fb});
    wr(ADDR_ATTEN_FILT, 4'h3, 16'h0054);
    chk("atten", 16'h0813, {3'h0, actl});
    chk("fb", 16'h0000, {11'h0, fb});
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_ATTEN_FILT, 4'h3, 16'(k) << 2);
      chk("hpf", 16'(k), {14'h0, actl.input_highpass_corner});
    end
    wr(ADDR_ATTEN_FILT, 4'h3, 16'h0200);
    for (int j = 0; j < 5; j++) begin
      wr(ADDR_BUF_FB, 4'h3, 16'h0001 << j);
      chk("fb", 16'h0001 << j, {11'h0, fb});
    end
    summarize();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule

// *** test/vpgc_checker.sv ***
`timescale 1ns/10ps
module vpgc_checker
  import vpgc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input vpgc_pwr_mode_t   power_mode,
  input vpgc_power_t      power_ctl,
  input vpgc_atten_t      atten_ctl,
  input wire logic [4:0]  buffer_fb_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic taken, mapped, pw_wr;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i inside {ADDR_TERM_GAIN, ADDR_POWER_MODE, ADDR_BUF_FB,
                                   ADDR_CHAN_GAIN, ADDR_ATTEN_FILT};
  assign pw_wr = taken && wb_we_i && wb_sel_i[1] && wb_adr_i == ADDR_POWER_MODE;
  a_ack_mapped: assert property (taken && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  a_err_unmapped: assert property (taken && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_medium_select: assert property (pw_wr && wb_dat_i[11:10] == 2'b10 |-> ##2
    power_mode == VPGC_PWR_MEDIUM) else $error("medium power not selected");
  a_low_select: assert property (pw_wr && wb_dat_i[11:10] == 2'b01 |-> ##2
    power_mode == VPGC_PWR_LOW) else $error("low power not selected");
  a_partial_off: assert property (pw_wr && wb_dat_i[15:14] == 2'b01 |-> ##2
    power_ctl.chain_partial_off) else $error("partial power-down missing");
  a_stage_off: assert property (pw_wr |-> ##2
    power_ctl.attenuator_gain_stage_off == $past(wb_dat_i[12], 2) &&
    power_ctl.input_amp_off == $past(wb_dat_i[13], 2)) else $error("stage power bits wrong");
  a_full_wins: assert property (power_ctl.chain_full_off |-> !power_ctl.chain_partial_off)
    else $error("full power-down not overriding partial");
  a_fb_gated: assert property (buffer_fb_active == (atten_ctl.gain_stage_test_route ?
    atten_ctl.buffer_feedback_code : 5'h00)) else $error("feedback outside test route");
  a_steps_gated: assert property (!atten_ctl.digital_atten_enable |->
    atten_ctl.digital_atten_steps == 3'h0) else $error("steps without digital enable");
  c_unmapped: cover property (taken && !mapped);
  c_full_off: cover property (power_ctl.chain_full_off);
  c_fb_route: cover property (buffer_fb_active != 5'h00);
endmodule
bind vpgc_regs vpgc_checker u_chk (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .power_mode(power_mode),
  .power_ctl(power_ctl), .atten_ctl(atten_ctl), .buffer_fb_active(buffer_fb_active));

// *** test/vpgc_host.sv ***
`timescale 1ns/10ps
module vpgc_host (
  input  wire logic        core_clk,
  input  wire logic        wb_ack_o,
  input  wire logic        wb_err_o,
  input  wire logic [31:0] wb_dat_o,
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic [7:0]       wb_adr_i,
  output logic [3:0]       wb_sel_i,
  output logic [31:0]      wb_dat_i
);
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // one classic cycle, held until ack or err is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [15:0] d, output logic [15:0] q, output logic e);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {16'h0000, d};
    do @(posedge core_clk); while (!(wb_ack_o || wb_err_o));
    q = wb_dat_o[15:0];
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~a;
    wb_dat_i <= ~wb_dat_i;
  endtask
endmodule
